// ===== core/led_drive.sv
// One indicator LED: brightness by pulse width, flashing on saturation
`timescale 1ns/1ps
module led_drive
	import rate_led_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  rate_led_pkg::chan_s src,
	input  wire logic        flash,
	output logic             led_q
);
	import rate_led_pkg::*;

	level_t pwm_q;
	level_t pwm_d;
	logic   led_d;

	// ======================================================================
	// Pulse width generator
	always_comb
	begin
		pwm_d = pwm_q + level_t'(1);
		if (src.sat)
			led_d = flash;
		else
			led_d = (pwm_q < src.lvl);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwm_q <= '0;
			led_q <= 1'b0;
		end
		else
		begin
			pwm_q <= pwm_d;
			led_q <= led_d;
		end
	end

	// ======================================================================
	// Checks
	sat_flash_a: assert property (@(posedge clk) disable iff (!nrst)
		src.sat |=> led_q == $past(flash))
		else $error("saturated LED does not follow flash phase");

	dark_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		(!src.sat && src.lvl == '0) [*2] |-> !led_q)
		else $error("zero level LED is lit");
endmodule

// ===== core/rate_led_indicator_select.sv
// Source selection, update timing and voice stealing for the rate LEDs
`timescale 1ns/1ps
`include "rate_led_map.svh"
module rate_led_indicator_select
	import rate_led_pkg::*;
#(
	parameter int NV             = `NUM_VOICES,
	parameter int FLASH_HALF_CYC = `FLASH_HALF_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
	parameter int UPDATE_CYC     = `UPDATE_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
)
(
	input  wire logic                  CLK,
	input  wire logic                  NRST,
	input  wire logic [3:0]            INDICATOR_SOURCE_SELECT,
	input  rate_led_pkg::pair_s        LFO,
	input  rate_led_pkg::pair_s        EXT_IN,
	input  wire logic                  EXTERNAL_SOURCE_SETTING,
	input  rate_led_pkg::pair_s        BUS [`NUM_BUS],
	input  rate_led_pkg::level_t       VOICE_ATTEN [NV],
	input  rate_led_pkg::level_t       VOICE_ENV [NV],
	input  wire logic                  ALL_BUSY,
	input  wire logic                  NEW_NOTE,
	output logic                       STEAL,
	output logic [$clog2(NV)-1:0]      STEAL_VOICE,
	output logic [1:0]                 LED
);
	import rate_led_pkg::*;

	localparam int VW = $clog2(NV);

	// ======================================================================
	// Parameter checks
	generate
		if (NV < 2)
			$error("NV must be at least 2");
		if (FLASH_HALF_CYC < 1 || UPDATE_CYC < 1)
			$error("timing counts must be at least 1");
	endgenerate

	// ======================================================================
	// Helpers
	function automatic level_t clamp_atten(input level_t a);
		clamp_atten = (a > `ATTEN_FLOOR) ? `ATTEN_FLOOR : a;
	endfunction

	function automatic logic [VW-1:0] quietest(input level_t att [NV]);
		level_t best;
		quietest = '0;
		best     = clamp_atten(att[0]);
		for (int i = 1; i < NV; i++)
		begin
			if (clamp_atten(att[i]) > best)
			begin
				best     = clamp_atten(att[i]);
				quietest = VW'(i);
			end
		end
	endfunction

	// ======================================================================
	// Update and flash dividers
	logic [31:0] upd_cnt_q;
	logic [31:0] upd_cnt_d;
	logic [31:0] fl_cnt_q;
	logic [31:0] fl_cnt_d;
	logic        flash_q;
	logic        flash_d;
	logic        tick;

	always_comb
	begin
		tick      = (upd_cnt_q == 32'(UPDATE_CYC - 1));
		upd_cnt_d = tick ? '0 : upd_cnt_q + 32'h1;
		flash_d   = flash_q;
		fl_cnt_d  = fl_cnt_q + 32'h1;
		if (fl_cnt_q == 32'(FLASH_HALF_CYC - 1))
		begin
			fl_cnt_d = '0;
			flash_d  = !flash_q;
		end
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			upd_cnt_q <= '0;
			fl_cnt_q  <= '0;
			flash_q   <= 1'b0;
		end
		else
		begin
			upd_cnt_q <= upd_cnt_d;
			fl_cnt_q  <= fl_cnt_d;
			flash_q   <= flash_d;
		end
	end

	// ======================================================================
	// Voice stealing
	logic          steal_d;
	logic [VW-1:0] voice_d;

	always_comb
	begin
		steal_d = NEW_NOTE && ALL_BUSY;
		voice_d = steal_d ? quietest(VOICE_ATTEN) : STEAL_VOICE;
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			STEAL       <= 1'b0;
			STEAL_VOICE <= '0;
		end
		else
		begin
			STEAL       <= steal_d;
			STEAL_VOICE <= voice_d;
		end
	end

	// ======================================================================
	// Source selection, latched once per update so both LEDs change together
	pair_s sel_q;
	pair_s sel_d;
	pair_s pick;

	always_comb
	begin
		pick = '0;
		if (INDICATOR_SOURCE_SELECT == `MODE_LFO)
			pick = LFO;
		else if (INDICATOR_SOURCE_SELECT == `MODE_INPUT)
			pick = EXT_IN;
		else if (INDICATOR_SOURCE_SELECT == `MODE_AUTO)
			pick = EXTERNAL_SOURCE_SETTING ? EXT_IN : LFO;
		else if (INDICATOR_SOURCE_SELECT >= `MODE_OUT_A &&
			INDICATOR_SOURCE_SELECT <= `MODE_SEND_B)
			pick = BUS[3'(INDICATOR_SOURCE_SELECT - `MODE_OUT_A)];
		else if (INDICATOR_SOURCE_SELECT == `MODE_STEAL)
		begin
			pick.left.lvl  = VOICE_ENV[STEAL_VOICE];
			pick.right.lvl = VOICE_ENV[STEAL_VOICE];
		end
		// Oscillators have no overload, so their flags never flash
		if (INDICATOR_SOURCE_SELECT == `MODE_LFO ||
			(INDICATOR_SOURCE_SELECT == `MODE_AUTO && !EXTERNAL_SOURCE_SETTING))
		begin
			pick.left.sat  = 1'b0;
			pick.right.sat = 1'b0;
		end
		sel_d = tick ? pick : sel_q;
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			sel_q <= '0;
		else
			sel_q <= sel_d;
	end

	// ======================================================================
	// LED drivers
	generate
		for (genvar g = 0; g < 2; g++)
		begin : drv
			led_drive u_drv
			(
				.clk   (CLK),
				.nrst  (NRST),
				.src   ((g == 0) ? sel_q.left : sel_q.right),
				.flash (flash_q),
				.led_q (LED[g])
			);
		end
	endgenerate

	// ======================================================================
	// Checks
	lfo_map_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && INDICATOR_SOURCE_SELECT == `MODE_LFO
		|=> sel_q.left.lvl == $past(LFO.left.lvl) && sel_q.right.lvl == $past(LFO.right.lvl))
		else $error("oscillator mode mapping wrong");

	input_map_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && INDICATOR_SOURCE_SELECT == `MODE_INPUT
		|=> sel_q.left == $past(EXT_IN.left) && sel_q.right == $past(EXT_IN.right))
		else $error("input mode mapping wrong");

	auto_ext_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && INDICATOR_SOURCE_SELECT == `MODE_AUTO && EXTERNAL_SOURCE_SETTING
		|=> sel_q == $past(EXT_IN))
		else $error("auto mode ignores external input");

	bus_chan_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && INDICATOR_SOURCE_SELECT == `MODE_OUT_C |=> sel_q == $past(BUS[2]))
		else $error("bus channel mapping wrong");

	hold_sel_a: assert property (@(posedge CLK) disable iff (!NRST)
		!tick |=> $stable(sel_q))
		else $error("selection changed between updates");

	steal_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
		NEW_NOTE && ALL_BUSY |=> STEAL ##1 (STEAL == $past(NEW_NOTE && ALL_BUSY)))
		else $error("steal pulse missing");

	// One check per voice: the stolen voice is the most decayed, ties go to the lowest index
	generate
		for (genvar v = 0; v < NV; v++)
		begin : pick_chk
			steal_pick_a: assert property (@(posedge CLK) disable iff (!NRST)
				STEAL |->
					(clamp_atten($past(VOICE_ATTEN[v]))
						< clamp_atten($past(VOICE_ATTEN[voice_d])))
					|| ((clamp_atten($past(VOICE_ATTEN[v]))
						== clamp_atten($past(VOICE_ATTEN[voice_d])))
						&& (VW'(v) >= STEAL_VOICE)))
				else $error("stolen voice not the most decayed");
		end
	endgenerate

	steal_env_a: assert property (@(posedge CLK) disable iff (!NRST)
		tick && INDICATOR_SOURCE_SELECT == `MODE_STEAL
		|=> sel_q.left.lvl == $past(VOICE_ENV[STEAL_VOICE]) && !sel_q.left.sat)
		else $error("steal brightness not from stolen envelope");
endmodule

// ===== inc/rate_led_map.svh
// Constants for the rate indicator LED source selection
// How it works
// - Oscillator mode: LED one follows oscillator one, LED two follows oscillator two.
// - External-input mode: LED one shows left input, LED two right input.
// - Every level mode drives LED brightness in proportion to its signal level.
// - A saturated input turns its LED from brightness to rapid flashing.
// - Auto mode shows oscillators, or input levels when the sound uses inputs.
// - Five bus settings: three outputs and two auxiliary sends.
// - Bus settings: LED one shows left channel, LED two right channel.
// - An overloaded selected bus makes its LED flash rapidly.
// - With all voices busy a new note steals the most decayed voice.
// - Voice levels are tracked from 0 down to -144 dB.
// - Steal mode: brightness follows envelope level of the stolen note.
`ifndef RATE_LED_MAP_SVH
`define RATE_LED_MAP_SVH

// ==========================================================================
// Display mode codes
`define MODE_LFO      4'h0
`define MODE_INPUT    4'h1
`define MODE_AUTO     4'h2
`define MODE_OUT_A    4'h3
`define MODE_OUT_B    4'h4
`define MODE_OUT_C    4'h5
`define MODE_SEND_A   4'h6
`define MODE_SEND_B   4'h7
`define MODE_STEAL    4'h8

// ==========================================================================
// Widths and ranges
`define LVL_W         8
`define NUM_BUS       5
`define NUM_VOICES    16
`define ATTEN_FLOOR   8'h90

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 10
`define FLASH_HALF_MS 50
`define UPDATE_MS     1
`define NS_PER_MS     1000000

`endif

// ===== inc/rate_led_pkg.sv
// Types shared by the rate indicator LED logic
`include "rate_led_map.svh"
package rate_led_pkg;
	typedef logic [`LVL_W-1:0] level_t;

	typedef struct packed
	{
		level_t lvl;
		logic   sat;
	} chan_s;

	typedef struct packed
	{
		chan_s left;
		chan_s right;
	} pair_s;
endpackage

// ===== tb/rate_led_indicator_select_tb_top.sv
// Self-checking bench for the rate indicator LED source selection
`timescale 1ns/1ps
`include "rate_led_map.svh"
module rate_led_indicator_select_tb_top;
	import rate_led_pkg::*;
	// Short counts keep the run brief; expectations below assume these values
	localparam int NV = 4;
	localparam int FLASH_HALF_CYC = 4;
	localparam int UPDATE_CYC = 3;

	logic        clk;
	logic        nrst;
	logic        ext_set;
	logic        all_busy;
	logic        new_note;
	logic [3:0]  mode;
	pair_s       lfo;
	pair_s       ext_in;
	pair_s       bus [`NUM_BUS];
	level_t      atten [NV];
	level_t      env [NV];
	logic        steal;
	logic [1:0]  steal_voice;
	logic [1:0]  led;
	int          n_mismatch = 0;
	int          n_tests = 0;

	rate_led_indicator_select #(
		.NV             (NV),
		.FLASH_HALF_CYC (FLASH_HALF_CYC),
		.UPDATE_CYC     (UPDATE_CYC)
	) DUT (
		.CLK                     (clk),
		.NRST                    (nrst),
		.INDICATOR_SOURCE_SELECT (mode),
		.LFO                     (lfo),
		.EXT_IN                  (ext_in),
		.EXTERNAL_SOURCE_SETTING (ext_set),
		.BUS                     (bus),
		.VOICE_ATTEN             (atten),
		.VOICE_ENV               (env),
		.ALL_BUSY                (all_busy),
		.NEW_NOTE                (new_note),
		.STEAL                   (steal),
		.STEAL_VOICE             (steal_voice),
		.LED                     (led)
	);

	// ==========================================================
	// Shared tasks
	task automatic results;
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// On-time over 256 cycles equals the level, whatever the PWM phase;
	// a flashing LED gives exactly half, since 256 is a whole number of periods
	task automatic look(input logic [3:0] m, output logic [15:0] c0, output logic [15:0] c1);
		mode = m;
		c0 = 16'h0;
		c1 = 16'h0;
		repeat (UPDATE_CYC + 5) @(negedge clk);
		repeat (256)
		begin
			@(negedge clk);
			c0 = c0 + ((led[0] === 1'b1) ? 16'h1 : 16'h0);
			c1 = c1 + ((led[1] === 1'b1) ? 16'h1 : 16'h0);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_osc;
		logic [15:0] a, b;
		lfo = {8'h40, 1'b1, 8'hc0, 1'b0};
		look(`MODE_LFO, a, b);
		chk(a, 16'h0040);
		chk(b, 16'h00c0);
	endtask

	task automatic t_input;
		logic [15:0] a, b;
		ext_in = {8'h20, 1'b0, 8'h10, 1'b1};
		look(`MODE_INPUT, a, b);
		chk(a, 16'h0020);
		chk(b, 16'h0080);
	endtask

	task automatic t_auto;
		logic [15:0] a, b;
		ext_set = 1'b0;
		look(`MODE_AUTO, a, b);
		chk(a, 16'h0040);
		chk(b, 16'h00c0);
		ext_set = 1'b1;
		look(`MODE_AUTO, a, b);
		chk(a, 16'h0020);
		chk(b, 16'h0080);
	endtask

	task automatic t_bus;
		logic [15:0] a, b;
		for (int i = 0; i < `NUM_BUS; i++)
		begin
			look(4'(`MODE_OUT_A + i), a, b);
			chk(a, 16'(16 * (i + 1)));
			chk(b, (i == 4) ? 16'h0080 : 16'(8 + i));
		end
	endtask

	// Two voices tie after clamping; the lower index must be taken
	task automatic t_steal;
		logic [15:0] a, b;
		atten = '{8'h10, 8'ha0, 8'h90, 8'h20};
		env = '{8'h30, 8'h50, 8'h70, 8'h01};
		all_busy = 1'b0;
		new_note = 1'b1;
		@(negedge clk);
		chk({15'h0, steal}, 16'h0);
		all_busy = 1'b1;
		@(negedge clk);
		chk({15'h0, steal}, 16'h1);
		chk({14'h0, steal_voice}, 16'h1);
		new_note = 1'b0;
		@(negedge clk);
		chk({15'h0, steal}, 16'h0);
		look(`MODE_STEAL, a, b);
		chk(a, 16'h0050);
		chk(b, 16'h0050);
	endtask

	task automatic t_dark;
		logic [15:0] a, b;
		look(4'h9, a, b);
		chk(a, 16'h0);
		chk(b, 16'h0);
	endtask

	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		nrst = 1'b0;
		ext_set = 1'b0;
		all_busy = 1'b0;
		new_note = 1'b0;
		mode = `MODE_LFO;
		lfo = '0;
		ext_in = '0;
		for (int i = 0; i < `NUM_BUS; i++)
		begin
			bus[i].left.lvl = level_t'(16 * (i + 1));
			bus[i].left.sat = 1'b0;
			bus[i].right.lvl = level_t'(8 + i);
			bus[i].right.sat = (i == 4);
		end
		for (int i = 0; i < NV; i++)
		begin
			atten[i] = '0;
			env[i] = '0;
		end
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_osc();
		t_input();
		t_auto();
		t_bus();
		t_steal();
		t_dark();
		results();
	end

	// Roughly 11 measurements of 264 cycles; ample margin on top
	initial
	begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule
